// ==== debug_regs.sv ====
// Debug status/control and breakpoint registers with halt control.
`timescale 1ns/10ps
module debug_regs
  import debug_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Decoded serial command
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  // CPU status
  input wire logic [ADDR_WIDTH-1:0] cpu_addr,
  input wire logic cpu_fetch,
  input wire logic insn_boundary,
  input wire logic tagged_at_queue_end,
  input wire logic cpu_in_wait_stop,
  input wire logic mem_access_fail,
  input wire logic resume_user,
  // Results
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic enter_background,
  output logic leave_wait_stop,
  output logic background_active,
  output logic tag_opcode
);
  // Registers live only here; no CPU address decode exists (see R1).
  logic background_permit_reg;
  logic breakpoint_enable_bit_reg;
  logic force_or_tag_select_reg;
  logic wait_stop_state_reg;
  logic wait_stop_failure_reg;
  logic [BKPT_WIDTH-1:0] bkpt_reg;
  logic [15:0] cmd_rdata_reg;
  logic cmd_rvalid_reg;
  logic active_reg;
  logic enter_reg;
  logic leave_reg;
  logic tag_reg;
  logic force_pending_reg;

  logic [7:0] status_value;
  logic wr_ctrl;
  logic wr_bkpt;
  logic rd_status;
  logic rd_bkpt;
  logic halt_cmd;
  logic force_hit;
  logic tag_hit;
  logic halt_req;
  logic go_background;
  logic active_next;

  assign wr_ctrl = cmd_valid && cmd_code == CMD_CONTROL_WRITE; // see R18
  assign rd_status = cmd_valid && cmd_code == CMD_STATUS_READ; // see R18
  assign wr_bkpt = cmd_valid && cmd_code == CMD_BKPT_WRITE; // see R19
  assign rd_bkpt = cmd_valid && cmd_code == CMD_BKPT_READ; // see R19, R16
  assign halt_cmd = cmd_valid && cmd_code == CMD_HALT;

  assign status_value = {background_permit_reg, active_reg, breakpoint_enable_bit_reg,
    force_or_tag_select_reg, 1'b0, wait_stop_state_reg, wait_stop_failure_reg,
    1'b0}; // see R20

  bkpt_compare #(
    .AW(ADDR_WIDTH)
  ) u_cmp (
    .enable(breakpoint_enable_bit_reg),
    .force_sel(force_or_tag_select_reg),
    .bkpt_addr(bkpt_reg[ADDR_WIDTH-1:0]), // see R15
    .cpu_addr(cpu_addr),
    .cpu_fetch(cpu_fetch),
    .force_hit(force_hit),
    .tag_hit(tag_hit)
  );

  // Halt sources: command, forced breakpoint at boundary, tagged opcode.
  assign halt_req = halt_cmd || (force_pending_reg && insn_boundary)
    || (tagged_at_queue_end && breakpoint_enable_bit_reg); // see R8, R9, R11
  assign go_background = halt_req && background_permit_reg && !active_reg; // see R2
  assign active_next = go_background ? 1'b1 : (resume_user ? 1'b0 : active_reg); // see R6

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      background_permit_reg <= 1'b0;
      breakpoint_enable_bit_reg <= 1'b0;
      force_or_tag_select_reg <= 1'b0;
      bkpt_reg <= BKPT_RESET;
    end else begin
      if (wr_ctrl && !active_reg) begin
        background_permit_reg <= background_permit_reg | cmd_wdata[BIT_PERMIT]; // see R3, R4
      end
      if (wr_ctrl) begin
        breakpoint_enable_bit_reg <= cmd_wdata[BIT_BKPT_EN];
        force_or_tag_select_reg <= cmd_wdata[BIT_FORCE_TAG]; // see R5
      end
      if (wr_bkpt) begin
        bkpt_reg <= cmd_wdata; // see R16
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      wait_stop_state_reg <= 1'b0;
      wait_stop_failure_reg <= 1'b0;
      force_pending_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      if (go_background) begin
        wait_stop_state_reg <= cpu_in_wait_stop; // see R10
      end else if (!active_reg) begin
        wait_stop_state_reg <= cpu_in_wait_stop; // see R10
      end
      if (mem_access_fail && cpu_in_wait_stop) begin
        wait_stop_failure_reg <= 1'b1; // see R13
      end else if (go_background) begin
        wait_stop_failure_reg <= 1'b0;
      end
      if (force_hit && !active_reg) begin
        force_pending_reg <= 1'b1; // see R8
      end else if (insn_boundary || !breakpoint_enable_bit_reg) begin
        force_pending_reg <= 1'b0; // see R7
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_rdata_reg <= 16'h0000;
      cmd_rvalid_reg <= 1'b0;
      enter_reg <= 1'b0;
      leave_reg <= 1'b0;
      tag_reg <= 1'b0;
    end else begin
      cmd_rvalid_reg <= rd_status || rd_bkpt;
      if (rd_status) begin
        cmd_rdata_reg <= {8'h00, status_value}; // see R18
      end else if (rd_bkpt) begin
        cmd_rdata_reg <= bkpt_reg; // see R19
      end
      enter_reg <= go_background;
      leave_reg <= go_background && cpu_in_wait_stop; // see R11
      tag_reg <= tag_hit; // see R9
    end
  end

  assign cmd_rdata = cmd_rdata_reg;
  assign cmd_rvalid = cmd_rvalid_reg;
  assign enter_background = enter_reg;
  assign leave_wait_stop = leave_reg;
  assign background_active = active_reg;
  assign tag_opcode = tag_reg;
endmodule

// ==== debug_regs_pkg.sv ====
// Constants for the debug controller status and breakpoint registers.
// Behaviour
// R1 - Registers reachable only by serial debug commands
// R2 - Permit bit gates entry to background mode
// R3 - Permit bit stays set until normal reset
// R4 - Permit writes ignored while background mode active
// R5 - Status bits are read-only to control writes
// R6 - Active bit shows background mode is on
// R7 - Breakpoint disabled ignores select and address
// R8 - Force select halts at next instruction boundary
// R9 - Tag select halts when tagged opcode executes
// R10 - Wait-stop bit shows wait, stop, or halt-from-wait
// R11 - Halt command still leaves wait or stop
// R12 - Host confirms active bit after forcing halt
// R13 - Failure bit set when access hits wait/stop
// R14 - Host recovers by halt, retry, then resume
// R15 - Breakpoint register 16 bits, 14-bit address
// R16 - Breakpoint commands serviced while user runs
// R17 - Host sets permit bit early in session
// R18 - Codes e4/c4 read and write status register
// R19 - Codes e2/c2 read and write breakpoint register
// R20 - Unassigned bits 3 and 0 read zero
package debug_regs_pkg;
  localparam logic [7:0] CMD_STATUS_READ = 8'he4;
  localparam logic [7:0] CMD_CONTROL_WRITE = 8'hc4;
  localparam logic [7:0] CMD_BKPT_READ = 8'he2;
  localparam logic [7:0] CMD_BKPT_WRITE = 8'hc2;
  localparam logic [7:0] CMD_HALT = 8'h90;
  localparam int BIT_PERMIT = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_BKPT_EN = 5;
  localparam int BIT_FORCE_TAG = 4;
  localparam int BIT_WAIT_STOP = 2;
  localparam int BIT_WS_FAIL = 1;
  localparam int ADDR_WIDTH = 14;
  localparam int BKPT_WIDTH = 16;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] BKPT_RESET = 16'h0000;
endpackage

// ==== bkpt_compare.sv ====
// Breakpoint address comparator with force and tag outputs.
`timescale 1ns/10ps
module bkpt_compare
  import debug_regs_pkg::*;
#(
  parameter int AW = ADDR_WIDTH
) (
  // Configuration
  input wire logic enable,
  input wire logic force_sel,
  input wire logic [AW-1:0] bkpt_addr,
  // CPU address
  input wire logic [AW-1:0] cpu_addr,
  input wire logic cpu_fetch,
  // Results
  output logic force_hit,
  output logic tag_hit
);
  logic match;
  assign match = enable && (cpu_addr == bkpt_addr); // see R7
  assign force_hit = match && force_sel; // see R8
  assign tag_hit = match && !force_sel && cpu_fetch; // see R9
endmodule

// ==== debug_regs_monitor.sv ====
// Port checker for the debug register block.
`timescale 1ns/10ps
module debug_regs_monitor
  import debug_regs_pkg::*;
(
  // Watched ports
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic enter_background,
  input wire logic background_active,
  input wire logic resume_user,
  input wire logic cpu_fetch,
  input wire logic cpu_in_wait_stop,
  input wire logic leave_wait_stop,
  input wire logic tag_opcode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire rs = cmd_valid && cmd_code == CMD_STATUS_READ;
  wire rb = cmd_valid && cmd_code == CMD_BKPT_READ;
  rd_ans_a: assert property (rs || rb |=> cmd_rvalid)
    else $error("read not answered");
  no_spur_a: assert property (cmd_rvalid |-> $past(rs || rb))
    else $error("answer without read");
  zero_bits_a: assert property (rs |=> cmd_rdata[15:8] == 8'h00 && !cmd_rdata[3] && !cmd_rdata[0])
    else $error("unused bits set");
  act_bit_a: assert property (rs |=> cmd_rdata[6] == $past(background_active))
    else $error("active bit wrong");
  permit_gate_a: assert property (rs |=> !cmd_rdata[6] || cmd_rdata[7])
    else $error("active without permit");
  entry_a: assert property ($rose(background_active) |-> enter_background)
    else $error("entry without pulse");
  leave_a: assert property ($fell(background_active) |-> $past(resume_user))
    else $error("left without resume");
  resume_a: assert property (resume_user && background_active && !cmd_valid |=> !background_active)
    else $error("resume ignored");
  leave_ws_a: assert property (leave_wait_stop |-> enter_background && $past(cpu_in_wait_stop))
    else $error("wait exit pulse wrong");
  tag_fetch_a: assert property (tag_opcode |-> $past(cpu_fetch))
    else $error("tag without fetch");
  cover property (leave_wait_stop);
  cover property (enter_background);
  cover property (rb);
  cover property (resume_user && background_active);
endmodule

// ==== debug_host.sv ====
// Debug host model issuing decoded serial commands.
`timescale 1ns/10ps
module debug_host (
  // Clock and answer
  input wire logic clk_sys,
  input wire logic [15:0] cmd_rdata,
  // Command
  output logic cmd_valid = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [15:0] cmd_wdata = 16'h0000
);
  task automatic send(input logic [7:0] c, input logic [15:0] w, output logic [15:0] d);
    @(posedge clk_sys);
    {cmd_valid, cmd_code, cmd_wdata} <= {1'b1, c, w};
    @(posedge clk_sys);
    {cmd_valid, cmd_code, cmd_wdata} <= {1'b0, ~c, ~w};
    #1 d = cmd_rdata;
  endtask
endmodule

// ==== debug_regs_bench.sv ====
// Testbench for the debug register block.
`timescale 1ns/10ps
`define CHK(e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch rdata exp %h got %h", e, s); end end
module debug_regs_bench
  import debug_regs_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, cpu_fetch = 1'b0, ws = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [13:0] cpu_addr = 14'h0000;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, rd;
  int err_total = 0;
  int total_checks = 0;
  always #25 clk_sys = ~clk_sys;
  debug_host H (.clk_sys(clk_sys), .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  debug_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch),
    .insn_boundary(ev[3]), .tagged_at_queue_end(ev[2]), .cpu_in_wait_stop(ws),
    .mem_access_fail(ev[1]), .resume_user(ev[0]), .cmd_rdata(cmd_rdata), .cmd_rvalid(),
    .enter_background(), .leave_wait_stop(), .background_active(), .tag_opcode());
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] w);
    H.send(c, w, rd);
  endtask
  task automatic st(input logic [7:0] e);
    H.send(CMD_STATUS_READ, 16'h0000, rd);
    `CHK({8'h00, e}, rd)
  endtask
  task automatic cpu(input logic [3:0] p);
    @(posedge clk_sys) ev <= p;
    @(posedge clk_sys) ev <= 4'h0;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    st(8'h00);
    cmd(CMD_BKPT_WRITE, 16'hc123);
    H.send(CMD_BKPT_READ, 16'h0000, rd);
    `CHK(16'hc123, rd)
    cmd(CMD_HALT, 16'h0000);
    st(8'h00);
    cmd(CMD_CONTROL_WRITE, 16'h00ff);
    st(8'hb0);
    cmd(CMD_HALT, 16'h0000);
    st(8'hf0);
    cmd(CMD_CONTROL_WRITE, 16'h0000);
    st(8'hc0);
    cpu(4'h1);
    st(8'h80);
    @(posedge clk_sys) ws <= 1'b1;
    cpu(4'h2);
    st(8'h86);
    cmd(CMD_HALT, 16'h0000);
    st(8'hc4);
    @(posedge clk_sys) ws <= 1'b0;
    cpu(4'h1);
    st(8'h80);
    cmd(CMD_CONTROL_WRITE, 16'h0010);
    @(posedge clk_sys) cpu_addr <= 14'h0123;
    cpu(4'h8);
    st(8'h90);
    cmd(CMD_CONTROL_WRITE, 16'h0030);
    cpu(4'h8);
    st(8'hf0);
    cpu(4'h1);
    cmd(CMD_CONTROL_WRITE, 16'h0020);
    @(posedge clk_sys) cpu_fetch <= 1'b1;
    cpu(4'h4);
    st(8'he0);
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    st(8'h00);
    H.send(CMD_BKPT_READ, 16'h0000, rd);
    `CHK(16'h0000, rd)
    finish_test;
  end
  initial begin
    #50000;
    err_total++;
    finish_test;
  end
endmodule
bind debug_regs debug_regs_monitor MON (.clk_sys(clk_sys), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
  .enter_background(enter_background), .background_active(background_active),
  .resume_user(resume_user), .cpu_fetch(cpu_fetch), .cpu_in_wait_stop(cpu_in_wait_stop),
  .leave_wait_stop(leave_wait_stop), .tag_opcode(tag_opcode));
